// File: include/flk_cfg.svh
// Purpose : constants of the lock / id / qpi command block
// Assumes : included by its bare name
// Notes   : definitions only
`ifndef FLK_CFG_SVH
`define FLK_CFG_SVH

// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define FLK_OP_LOCK     8'h36
`define FLK_OP_UNLOCK   8'h39
`define FLK_OP_RDLOCK   8'h3D
`define FLK_OP_GLOCK    8'h7E
`define FLK_OP_GUNLOCK  8'h98
`define FLK_OP_ID_DUAL  8'h92
`define FLK_OP_ID_QUAD  8'h94
`define FLK_OP_UID      8'h4B
`define FLK_OP_SETPARM  8'hC0
`define FLK_OP_BURST    8'h0C
`define FLK_OP_QPI_EN   8'h38
`define FLK_OP_QPI_EX   8'hFF

// ------------------------------------------------------------
// field positions, lengths and reset values
// ------------------------------------------------------------
`define FLK_OP_BITS     6'h08
`define FLK_ADDR_BITS   6'h18
`define FLK_MODE_BITS   6'h08
`define FLK_QUAD_DUMMY  4'h4
`define FLK_UID_DUM_SPI 4'h8
`define FLK_UID_DUM_QPI 4'h2
`define FLK_DUM_4       4'h4
`define FLK_DUM_6       4'h6
`define FLK_DUM_8       4'h8
`define FLK_DUM_MSB     5
`define FLK_DUM_LSB     4
`define FLK_WRAP_MSB    1
`define FLK_WRAP_LSB    0
`define FLK_DUM_RST     2'h0
`define FLK_WRAP_RST    2'h0
`define FLK_WRAP_MIN    24'h000008
`define FLK_LOCK_LSB    16
`define FLK_LOCK_RST    1'b1
`define FLK_OE_X1       4'h2
`define FLK_OE_X2       4'h3
`define FLK_OE_X4       4'hF
`define FLK_SYNC_BITS   6

`endif

// File: include/flk_pkg.sv
// Purpose : shared types of the lock / id / qpi command block
// Assumes : nothing
// Notes   : constants live in flk_cfg.svh
package flk_pkg;

   // command phase within one chip-select frame
   typedef enum logic [2:0] {
      FLK_PH_OP   = 3'b000,
      FLK_PH_ADDR = 3'b001,
      FLK_PH_MODE = 3'b010,
      FLK_PH_DUM  = 3'b011,
      FLK_PH_OUT  = 3'b100,
      FLK_PH_PARM = 3'b101,
      FLK_PH_END  = 3'b110,
      FLK_PH_IGN  = 3'b111
   } flk_phase_t;

endpackage

// File: include/flk_lock_if.sv
// Purpose : carrier between command logic and lock bit store
// Assumes : one clock domain
// Notes   : ctl drives, mem answers with registered bits
`timescale 1ns/100ps
interface flk_lock_if #(parameter int AW = 7);
   logic          wr_en;
   logic          wr_val;
   logic [AW-1:0] wr_idx;
   logic          all_en;
   logic          all_val;
   logic [AW-1:0] rd_idx;
   logic          rd_bit;
   logic [AW-1:0] chk_idx;
   logic          chk_bit;
   modport ctl (output wr_en, wr_val, wr_idx, all_en, all_val, rd_idx, chk_idx, input rd_bit, chk_bit);
   modport mem (input wr_en, wr_val, wr_idx, all_en, all_val, rd_idx, chk_idx, output rd_bit, chk_bit);
endinterface

// File: src/flk_lock_mem.sv
// Purpose : volatile block/sector lock bits
// Assumes : one write and two registered reads per clock
// Notes   : every bit comes out of reset locked
`timescale 1ns/100ps
`include "flk_cfg.svh"
module flk_lock_mem #(
   parameter int AW = 7
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // lock store port
   flk_lock_if.mem  lk
);
   import flk_pkg::*;

   localparam int N = 1 << AW;

   typedef struct packed {
      logic [N-1:0] bits;
      logic         rd;
      logic         chk;
   } flk_mem_st_t;

   flk_mem_st_t s_ff;
   flk_mem_st_t nxt_s;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      if (lk.all_en) begin
         nxt_s.bits = {N{lk.all_val}};            // R7 R8
      end else if (lk.wr_en) begin
         nxt_s.bits[lk.wr_idx] = lk.wr_val;
      end
      nxt_s.rd  = s_ff.bits[lk.rd_idx];
      nxt_s.chk = s_ff.bits[lk.chk_idx];
   end

   // registered state, all locked after reset
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff      <= '0;
         s_ff.bits <= {N{`FLK_LOCK_RST}};         // R2
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign lk.rd_bit  = s_ff.rd;
   assign lk.chk_bit = s_ff.chk;
endmodule

// File: src/flk_cmd.sv
// Purpose : serial command handling for lock, id, read parameters and qpi
// Assumes : sclk, cs_n and io pins are asynchronous to ref_clk
// Notes   : sclk is oversampled, so it must stay well below ref_clk / 4
//
// Functional notes
// R1: lock bits protect only when scheme select set
// R2: lock bits volatile, all set after reset
// R3: host unlocks with 39h plus address
// R4: lock instructions need write enable latch set
// R5: 3Dh readback shifted msb first on falls
// R6: readback lsb set means region locked
// R7: 7Eh sets every lock bit
// R8: 98h clears every lock bit
// R9: 92h id read two bits per clock
// R10: host sends mode bits with upper nibble ones
// R11: 94h id read, mode, four dummies, x4
// R12: ids alternate until chip select rises
// R13: 4Bh returns 128-bit unique number after dummy byte
// R14: read parameter setting only accepted in qpi
// R15: dummy field selects 4, 6 or 8 clocks
// R16: wrap field selects 8 to 64 bytes
// R17: reset gives 8-byte wrap, 4 dummies
// R18: host resets dummy count after entering qpi
// R19: spi wrap bits set wrap, kept across modes
// R20: qpi burst read wraps within wrap boundary
// R21: 38h enters qpi only with quad enable
// R22: entering qpi keeps latch, suspend, wrap
// R23: FFh leaves qpi, keeps latch, suspend, wrap
// R24: qpi carries every phase on four lines; here 92h still uses two lines after its opcode
`timescale 1ns/100ps
`include "flk_cfg.svh"
module flk_cmd #(
   parameter int           LOCK_AW = 7,
   parameter logic [7:0]   MFR_ID  = 8'hA5,     // arbitrary value
   parameter logic [7:0]   DEV_ID  = 8'h5A,     // arbitrary value
   parameter logic [127:0] UID     = 128'h0123456789ABCDEF0F1E2D3C4B5A6978  // arbitrary value
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // serial pins
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic [3:0]  io_in,
   output logic [3:0]       io_out,
   output logic [3:0]       io_oe,
   // status bits from the status registers
   input  wire logic        write_enable_latch,
   input  wire logic        quad_enable,
   input  wire logic        protect_scheme_select,
   input  wire logic        legacy_protect_hit,
   input  wire logic [1:0]  spi_wrap_bits,
   input  wire logic        spi_wrap_set,
   input  wire logic        soft_reset,
   // protection query
   input  wire logic [23:0] prot_addr,
   output logic             write_protected,
   // array read side of burst with wrap
   input  wire logic [7:0]  array_data,
   output logic             burst_active,
   output logic [23:0]      burst_addr,
   // mode and settings
   output logic             qpi_mode,
   output logic [1:0]       dummy_count_field,
   output logic [1:0]       wrap_length_field
);
   import flk_pkg::*;

   typedef struct packed {
      logic [5:0]  sy1;
      logic [5:0]  sy2;
      logic        pclk;
      logic        pcs;
      flk_phase_t  ph;
      logic [7:0]  op;
      logic [23:0] sh;
      logic [5:0]  cnt;
      logic [3:0]  dcnt;
      logic        qpi;
      logic [1:0]  dum;
      logic [1:0]  wrap;
      logic [7:0]  b0;
      logic [7:0]  b1;
      logic [1:0]  qv;
      logic [7:0]  osh;
      logic [3:0]  oleft;
      logic [3:0]  oe;
      logic [3:0]  oout;
      logic [3:0]  idx;
      logic        armed;
      logic        prod;
      logic [23:0] baddr;
      logic        wp;
   } flk_st_t;

   flk_st_t s_ff;
   flk_st_t nxt_s;

   flk_lock_if #(.AW(LOCK_AW)) lk ();

   flk_lock_mem #(.AW(LOCK_AW)) u_mem (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .lk      (lk)
   );

   // ------------------------------------------------------------
   // pin sampling and edge detection
   // ------------------------------------------------------------
   logic       cs_q;
   logic       clk_q;
   logic [3:0] io_q;
   logic       rise;
   logic       fall;
   logic       cs_up;

   assign cs_q  = s_ff.sy2[5];
   assign clk_q = s_ff.sy2[4];
   assign io_q  = s_ff.sy2[3:0];
   assign rise  = !cs_q && clk_q && !s_ff.pclk;
   assign fall  = !cs_q && !clk_q && s_ff.pclk;
   assign cs_up = cs_q && !s_ff.pcs;

   // ------------------------------------------------------------
   // lane width of the current phase
   // ------------------------------------------------------------
   logic [2:0] w;
   logic [3:0] win;
   always_comb begin
      w = s_ff.qpi ? 3'h4 : 3'h1; // R24
      if (s_ff.ph != FLK_PH_OP && s_ff.op == `FLK_OP_ID_DUAL) begin
         w = 3'h2; // R9
      end else if (s_ff.ph != FLK_PH_OP && s_ff.op == `FLK_OP_ID_QUAD) begin
         w = 3'h4; // R11
      end
      unique case (w)
         3'h4:    win = io_q;
         3'h2:    win = {2'h0, io_q[1:0]};
         default: win = {3'h0, io_q[0]};
      endcase
   end

   // incoming shift register and bit count after this edge
   logic [23:0] nsh;
   logic [5:0]  ncnt;
   always_comb begin
      unique case (w)
         3'h4:    nsh = {s_ff.sh[19:0], win};
         3'h2:    nsh = {s_ff.sh[21:0], win[1:0]};
         default: nsh = {s_ff.sh[22:0], win[0]};
      endcase
      ncnt = s_ff.cnt + {3'h0, w};
   end

   // ------------------------------------------------------------
   // burst wrap address and dummy count decode
   // ------------------------------------------------------------
   logic [23:0] wlen;
   logic [23:0] bnext;
   logic [3:0]  bdum;
   always_comb begin
      wlen  = `FLK_WRAP_MIN << s_ff.wrap; // R16
      bnext = (s_ff.baddr & ~(wlen - 24'h1)) | ((s_ff.baddr + 24'h1) & (wlen - 24'h1)); // R20
      unique case (s_ff.dum)
         2'b00:   bdum = `FLK_DUM_4; // R15
         2'b01:   bdum = `FLK_DUM_6;
         default: bdum = `FLK_DUM_8;
      endcase
   end

   // byte offered to the output buffer
   logic [7:0] pbyte;
   always_comb begin
      unique case (s_ff.op)
         `FLK_OP_RDLOCK:  pbyte = {7'h00, lk.rd_bit}; // R6
         `FLK_OP_ID_DUAL,
         `FLK_OP_ID_QUAD: pbyte = s_ff.idx[0] ? DEV_ID : MFR_ID; // R12
         `FLK_OP_UID:     pbyte = UID[{~s_ff.idx, 3'h0} +: 8]; // R13
         default:         pbyte = array_data;
      endcase
   end

   // ------------------------------------------------------------
   // execute on deselect
   // ------------------------------------------------------------
   logic done;
   logic ex_one;
   logic ex_all;
   assign done   = cs_up && s_ff.ph == FLK_PH_END;
   assign ex_one = done && write_enable_latch &&
                   (s_ff.op == `FLK_OP_LOCK || s_ff.op == `FLK_OP_UNLOCK);      // R4
   assign ex_all = done && write_enable_latch &&
                   (s_ff.op == `FLK_OP_GLOCK || s_ff.op == `FLK_OP_GUNLOCK);    // R4

   // lock store requests
   always_comb begin
      lk.wr_en   = ex_one;
      lk.wr_val  = s_ff.op == `FLK_OP_LOCK; // R3
      lk.wr_idx  = s_ff.sh[`FLK_LOCK_LSB +: LOCK_AW];
      lk.all_en  = ex_all || soft_reset;
      lk.all_val = soft_reset || s_ff.op == `FLK_OP_GLOCK; // R7 R8 R2
      lk.rd_idx  = s_ff.sh[`FLK_LOCK_LSB +: LOCK_AW];
      lk.chk_idx = prot_addr[`FLK_LOCK_LSB +: LOCK_AW];
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic       push;
   logic       pop;
   logic [7:0] ob;
   logic [2:0] wo;
   always_comb begin
      nxt_s      = s_ff;
      nxt_s.sy1  = {cs_n, sclk, io_in};
      nxt_s.sy2  = s_ff.sy1;
      nxt_s.pclk = clk_q;
      nxt_s.pcs  = cs_q;
      nxt_s.wp   = protect_scheme_select ? lk.chk_bit : legacy_protect_hit; // R1
      nxt_s.prod = s_ff.armed || s_ff.prod; // keeps bytes coming until deselect, R12
      push       = 1'b0;
      pop        = 1'b0;
      ob         = 8'h00;
      wo         = w;

      // mode and setting changes
      if (done && s_ff.op == `FLK_OP_SETPARM && s_ff.qpi) begin
         nxt_s.dum  = s_ff.sh[`FLK_DUM_MSB:`FLK_DUM_LSB]; // R14 R15
         nxt_s.wrap = s_ff.sh[`FLK_WRAP_MSB:`FLK_WRAP_LSB]; // R16
      end
      if (done && s_ff.op == `FLK_OP_QPI_EN && quad_enable) begin
         nxt_s.qpi = 1'b1; // R21 R22
      end
      if (done && s_ff.op == `FLK_OP_QPI_EX && s_ff.qpi) begin
         nxt_s.qpi = 1'b0; // R23
      end
      if (spi_wrap_set && !s_ff.qpi) begin
         nxt_s.wrap = spi_wrap_bits; // R19
      end
      if (soft_reset) begin
         nxt_s.dum  = `FLK_DUM_RST; // R17
         nxt_s.wrap = `FLK_WRAP_RST;
      end

      if (cs_q) begin
         // idle frame state, ends any instruction
         nxt_s.ph    = FLK_PH_OP;                                     // R12
         nxt_s.cnt   = 6'h00;
         nxt_s.qv    = 2'h0;
         nxt_s.oleft = 4'h0;
         nxt_s.oe    = 4'h0;
         nxt_s.armed = 1'b0;
         nxt_s.prod  = 1'b0;
      end else if (rise) begin
         unique case (s_ff.ph)
            FLK_PH_OP: begin
               nxt_s.sh  = nsh;
               nxt_s.cnt = ncnt;
               if (ncnt == `FLK_OP_BITS) begin
                  nxt_s.op  = nsh[7:0];
                  nxt_s.cnt = 6'h00;
                  unique case (nsh[7:0])
                     `FLK_OP_LOCK, `FLK_OP_UNLOCK, `FLK_OP_RDLOCK, `FLK_OP_UID,
                     `FLK_OP_ID_DUAL, `FLK_OP_ID_QUAD: nxt_s.ph = FLK_PH_ADDR;
                     `FLK_OP_BURST:   nxt_s.ph = s_ff.qpi ? FLK_PH_ADDR : FLK_PH_IGN;
                     `FLK_OP_SETPARM: nxt_s.ph = s_ff.qpi ? FLK_PH_PARM : FLK_PH_IGN;  // R14
                     `FLK_OP_GLOCK, `FLK_OP_GUNLOCK, `FLK_OP_QPI_EN,
                     `FLK_OP_QPI_EX:  nxt_s.ph = FLK_PH_END;
                     default:         nxt_s.ph = FLK_PH_IGN;
                  endcase
               end
            end
            FLK_PH_ADDR: begin
               nxt_s.sh  = nsh;
               nxt_s.cnt = ncnt;
               if (ncnt == `FLK_ADDR_BITS) begin
                  nxt_s.cnt   = 6'h00;
                  nxt_s.baddr = nsh;
                  nxt_s.idx   = 4'h0;
                  unique case (s_ff.op)
                     `FLK_OP_RDLOCK: begin
                        nxt_s.ph    = FLK_PH_OUT;                     // R5
                        nxt_s.armed = 1'b1;
                     end
                     `FLK_OP_ID_DUAL, `FLK_OP_ID_QUAD: nxt_s.ph = FLK_PH_MODE;  // R10
                     `FLK_OP_UID: begin
                        nxt_s.ph   = FLK_PH_DUM;
                        nxt_s.dcnt = s_ff.qpi ? `FLK_UID_DUM_QPI : `FLK_UID_DUM_SPI;
                     end
                     `FLK_OP_BURST: begin
                        nxt_s.ph   = FLK_PH_DUM;
                        nxt_s.dcnt = bdum;                            // R15
                     end
                     default: nxt_s.ph = FLK_PH_END;
                  endcase
               end
            end
            FLK_PH_MODE: begin
               nxt_s.cnt = ncnt;
               if (ncnt == `FLK_MODE_BITS) begin
                  nxt_s.cnt = 6'h00;
                  if (s_ff.op == `FLK_OP_ID_QUAD) begin
                     nxt_s.ph   = FLK_PH_DUM;                         // R11
                     nxt_s.dcnt = `FLK_QUAD_DUMMY;
                  end else begin
                     nxt_s.ph    = FLK_PH_OUT;                        // R9
                     nxt_s.armed = 1'b1;
                  end
               end
            end
            FLK_PH_DUM: begin
               nxt_s.dcnt = s_ff.dcnt - 4'h1;
               if (s_ff.dcnt == 4'h1) begin
                  nxt_s.ph    = FLK_PH_OUT;
                  nxt_s.armed = 1'b1;
               end
            end
            FLK_PH_PARM: begin
               nxt_s.sh  = nsh;
               nxt_s.cnt = ncnt;
               if (ncnt == `FLK_OP_BITS) begin
                  nxt_s.ph = FLK_PH_END;
               end
            end
            FLK_PH_END: nxt_s.ph = FLK_PH_IGN;     // extra clocks void the instruction
            FLK_PH_OUT, FLK_PH_IGN: nxt_s.ph = s_ff.ph;
         endcase
      end

      // output serializer, one lane group per falling edge
      if (!cs_q && s_ff.ph == FLK_PH_OUT) begin
         nxt_s.armed = 1'b0;
         if (fall && (s_ff.oleft != 4'h0 || s_ff.qv != 2'h0)) begin
            if (s_ff.oleft == 4'h0) begin
               ob  = s_ff.b0;
               pop = 1'b1;
            end else begin
               ob  = s_ff.osh;
            end
            unique case (wo)
               3'h4: begin
                  nxt_s.oout = ob[7:4]; // R24
                  nxt_s.osh  = {ob[3:0], 4'h0};
                  nxt_s.oe   = `FLK_OE_X4;
               end
               3'h2: begin
                  nxt_s.oout = {2'h0, ob[7:6]}; // R9
                  nxt_s.osh  = {ob[5:0], 2'h0};
                  nxt_s.oe   = `FLK_OE_X2;
               end
               default: begin
                  nxt_s.oout = {2'h0, ob[7], 1'b0}; // R5
                  nxt_s.osh  = {ob[6:0], 1'b0};
                  nxt_s.oe   = `FLK_OE_X1;
               end
            endcase
            nxt_s.oleft = (pop ? 4'h8 : s_ff.oleft) - {1'b0, wo};
         end
         // two-entry buffer between byte source and serializer
         push = s_ff.prod && (s_ff.qv != 2'h2 || pop);
         unique case ({push, pop})
            2'b10: begin
               if (s_ff.qv == 2'h0) begin
                  nxt_s.b0 = pbyte;
               end else begin
                  nxt_s.b1 = pbyte;
               end
               nxt_s.qv = s_ff.qv + 2'h1;
            end
            2'b01: begin
               nxt_s.b0 = s_ff.b1;
               nxt_s.qv = s_ff.qv - 2'h1;
            end
            2'b11: begin
               nxt_s.b0 = (s_ff.qv == 2'h1) ? pbyte : s_ff.b1;
               nxt_s.b1 = pbyte;
            end
            default: nxt_s.qv = s_ff.qv;
         endcase
         if (push) begin
            nxt_s.idx = s_ff.idx + 4'h1;
            if (s_ff.op == `FLK_OP_BURST) begin
               nxt_s.baddr = bnext;                                   // R20
            end
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff      <= '0;
         s_ff.sy1  <= {`FLK_SYNC_BITS{1'b1}};
         s_ff.sy2  <= {`FLK_SYNC_BITS{1'b1}};
         s_ff.pcs  <= 1'b1;
         s_ff.ph   <= FLK_PH_OP;
         s_ff.qpi  <= 1'b0; // R21
         s_ff.dum  <= `FLK_DUM_RST; // R17
         s_ff.wrap <= `FLK_WRAP_RST;
         s_ff.wp   <= `FLK_LOCK_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign io_out            = s_ff.oout;
   assign io_oe             = s_ff.oe;
   assign write_protected   = s_ff.wp;
   assign burst_active      = s_ff.ph == FLK_PH_OUT && s_ff.op == `FLK_OP_BURST;
   assign burst_addr        = s_ff.baddr;
   assign qpi_mode          = s_ff.qpi;
   assign dummy_count_field = s_ff.dum;
   assign wrap_length_field = s_ff.wrap;
endmodule

// File: sim/flk_host.sv
// Purpose: serial host model for the command block
// Assumes: every edge placed 1 ns after ref_clk rises
// Notes: sclk rests low, released lines show inverse data
`timescale 1ns/100ps
module flk_host (
   // clock
   input  wire logic       ref_clk,
   // serial pins
   output logic            sclk,
   output logic            cs_n,
   output logic [3:0]      io_in,
   input  wire logic [3:0] io_out
);
   // idle link
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      io_in = 4'h0;
   end
   // half of the 48 ns link period
   task half();
      repeat (6) @(posedge ref_clk);
      #1;
   endtask
   // shift n bits msb first, w lanes per rise
   task put(input logic [31:0] v, input int n, input int w);
      cs_n = 1'b0;
      for (int i = n; i > 0; i -= w) begin
         io_in = 4'((v >> (i - w)) & ((1 << w) - 1));
         half();
         sclk = 1'b1;
         half();
         sclk = 1'b0;
      end
      io_in = ~io_in;
   endtask
   // collect n bits, sampled at the rise after each fall
   task get(input int n, input int w, output logic [63:0] r);
      r = '0;
      for (int i = 0; i < n; i += w) begin
         half();
         sclk = 1'b1;
         r = (r << w) | 64'(w == 1 ? io_out[1] : io_out & 4'((1 << w) - 1));
         half();
         sclk = 1'b0;
      end
   endtask
   // deselect for two link periods
   task stop();
      half();
      cs_n = 1'b1;
      repeat (4) half();
   endtask
endmodule

// File: sim/flk_cmd_asserts.sv
// Purpose: port checker of the command block
// Assumes: one ref_clk domain
// Notes: bound to flk_cmd
`timescale 1ns/100ps
module flk_cmd_asserts (
   // all block ports
   input wire logic ref_clk, arst_n, sclk, cs_n,
   input wire logic [3:0] io_in, io_out, io_oe,
   input wire logic write_enable_latch, quad_enable, protect_scheme_select,
   input wire logic legacy_protect_hit, spi_wrap_set, soft_reset,
   input wire logic [1:0] spi_wrap_bits, dummy_count_field, wrap_length_field,
   input wire logic [23:0] prot_addr, burst_addr,
   input wire logic [7:0] array_data,
   input wire logic write_protected, burst_active, qpi_mode
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // cycles with chip select high
   logic [3:0] hi_ff;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) hi_ff <= 4'h0;
      else hi_ff <= cs_n ? (hi_ff == 4'hF ? hi_ff : hi_ff + 4'h1) : 4'h0;
   end
   sequence s_legacy;
      !protect_scheme_select && $stable(legacy_protect_hit) && $stable(prot_addr);
   endsequence
   sequence s_wrap_take;
      spi_wrap_set && !qpi_mode && !soft_reset;
   endsequence
   a_oe_release: assert property (hi_ff > 4'h8 |-> io_oe == 4'h0)
      else $error("lanes driven while deselected");
   a_oe_width: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("odd lane enable");
   a_qpi_entry: assert property ($rose(qpi_mode) |-> quad_enable && cs_n)
      else $error("qpi entered wrongly");
   a_qpi_exit: assert property ($fell(qpi_mode) |-> cs_n)
      else $error("qpi left mid frame");
   a_parm_qpi: assert property ($changed(dummy_count_field) |-> qpi_mode || $past(soft_reset))
      else $error("dummy field changed in spi");
   a_wrap_hold: assert property ($changed(wrap_length_field) |-> qpi_mode || $past(spi_wrap_set || soft_reset))
      else $error("wrap field changed");
   a_wrap_take: assert property (s_wrap_take |=> wrap_length_field == $past(spi_wrap_bits))
      else $error("wrap bits not taken");
   a_soft_clear: assert property (soft_reset |=> dummy_count_field == 2'h0 && wrap_length_field == 2'h0)
      else $error("fields not cleared");
   a_legacy_pass: assert property (s_legacy [*3] |-> write_protected == legacy_protect_hit)
      else $error("legacy protection not followed");
   a_burst_qpi: assert property (burst_active |-> qpi_mode)
      else $error("burst outside qpi");
endmodule
bind flk_cmd flk_cmd_asserts chk_u (.*);

// File: sim/flash_lock_id_qpi_commands_bench.sv
// Purpose: self-checking bench of the command block
// Assumes: host model makes all frames
// Notes: ids are arbitrary values
`timescale 1ns/100ps
`include "flk_cfg.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; $display("unexpected %0t got %h exp %h", $time, g, e); end end
module flash_lock_id_qpi_commands_bench;
   localparam logic [7:0] MFR = 8'hC3; // arbitrary value
   localparam logic [7:0] DEV = 8'h3C; // arbitrary value
   localparam logic [127:0] UIDV = 128'h1122334455667788_99AABBCCDDEEFF00; // arbitrary value
   logic ref_clk = 1'b0, arst_n = 1'b0;
   logic write_enable_latch = 1'b0, quad_enable = 1'b0, protect_scheme_select = 1'b1;
   logic legacy_protect_hit = 1'b0, spi_wrap_set = 1'b0, soft_reset = 1'b0;
   logic [1:0] spi_wrap_bits = 2'h0;
   logic [23:0] prot_addr = 24'h0;
   wire logic sclk, cs_n, write_protected, burst_active, qpi_mode;
   wire logic [3:0] io_in, io_out, io_oe;
   wire logic [1:0] dummy_count_field, wrap_length_field;
   wire logic [23:0] burst_addr;
   wire logic [7:0] array_data = burst_addr[7:0];
   logic [63:0] exp_q[$], got_q[$], g, e, r;
   logic [31:0] lfsr = 32'hF60A;
   logic [23:0] a;
   int failures = 0, check_count = 0;
   always #2 ref_clk = ~ref_clk;
   flk_cmd #(.MFR_ID(MFR), .DEV_ID(DEV), .UID(UIDV)) dut_u (.*);
   flk_host host_u (.*);
   // compare each result with the oldest note
   always @(posedge ref_clk) begin
      while (got_q.size() > 0) begin
         g = got_q.pop_front();
         e = exp_q.pop_front();
         `CHK(g, e)
      end
   end
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task see(input logic [63:0] x, y);
      exp_q.push_back(x);
      got_q.push_back(y);
   endtask
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // 0 soft reset, 1 wrap set
   task pulse(input int k);
      tick(1);
      if (k) spi_wrap_set = 1'b1;
      else soft_reset = 1'b1;
      tick(1);
      {spi_wrap_set, soft_reset} = 2'h0;
      tick(3);
   endtask
   // opcode, address, mode byte, dummies, read
   task frm(input logic [7:0] op, input int ow, input logic [23:0] ad, input int an, input int aw,
            input logic [7:0] m, input int mn, input int dn, input int rn, input int rw);
      host_u.put(32'(op), 8, ow);
      if (an > 0) host_u.put(32'(ad), an, aw);
      if (mn > 0) host_u.put(32'(m), mn, aw);
      if (dn > 0) host_u.put(32'h0, dn * aw, aw);
      r = '0;
      if (rn > 0) host_u.get(rn, rw, r);
      host_u.stop();
   endtask
   task rdl(input int w);
      frm(`FLK_OP_RDLOCK, w, a, 24, w, 8'h00, 0, 0, 8, w);
   endtask
   task cmd(input logic [7:0] op, input int w, input int an);
      frm(op, w, a, an, w, 8'h00, 0, 0, 0, w);
   endtask
   task results();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog
   initial begin
      #300000;
      failures++;
      results();
   end
   // main sequence
   initial begin
      tick(2);
      arst_n = 1'b1;
      tick(4);
      see(64'h20, {write_protected, qpi_mode, dummy_count_field, wrap_length_field});
      a = 24'(rnd()) & 24'h7F0000;
      prot_addr = a;
      rdl(1);
      see(64'h1, r);
      cmd(`FLK_OP_UNLOCK, 1, 24);
      rdl(1);
      see(64'h1, r);
      write_enable_latch = 1'b1;
      cmd(`FLK_OP_UNLOCK, 1, 24);
      rdl(1);
      see(64'h0, r);
      see(64'h0, write_protected);
      protect_scheme_select = 1'b0;
      repeat (2) begin
         legacy_protect_hit = 1'(rnd());
         tick(4);
         see(legacy_protect_hit, write_protected);
      end
      protect_scheme_select = 1'b1;
      cmd(`FLK_OP_GLOCK, 1, 0);
      rdl(1);
      see(64'h1, r);
      cmd(`FLK_OP_GUNLOCK, 1, 0);
      rdl(1);
      see(64'h0, r);
      frm(`FLK_OP_ID_DUAL, 1, 24'h0, 24, 2, 8'hF0, 8, 0, 32, 2);
      see({MFR, DEV, MFR, DEV}, r);
      frm(`FLK_OP_UID, 1, 24'h0, 24, 1, 8'h00, 0, 8, 64, 1);
      see(UIDV[127:64], r);
      cmd(`FLK_OP_QPI_EN, 1, 0);
      see(64'h0, qpi_mode);
      spi_wrap_bits = 2'(rnd()) | 2'h1;
      pulse(1);
      see(spi_wrap_bits, {dummy_count_field, wrap_length_field});
      frm(`FLK_OP_SETPARM, 1, a, 0, 1, 8'h33, 8, 0, 0, 1);
      see(spi_wrap_bits, {dummy_count_field, wrap_length_field});
      quad_enable = 1'b1;
      frm(`FLK_OP_ID_QUAD, 1, 24'h0, 24, 4, 8'hF0, 8, 4, 32, 4);
      see({MFR, DEV, MFR, DEV}, r);
      cmd(`FLK_OP_QPI_EN, 1, 0);
      see({1'b1, spi_wrap_bits}, {qpi_mode, wrap_length_field});
      for (int i = 0; i < 4; i++) begin
         frm(`FLK_OP_SETPARM, 4, a, 0, 4, 8'(i * 17), 8, 0, 0, 4);
         see(64'(i * 5), {dummy_count_field, wrap_length_field});
      end
      frm(`FLK_OP_BURST, 4, 24'h00003E, 24, 4, 8'h00, 0, 8, 32, 4);
      see(64'h3E3F0001, r);
      rdl(4);
      see(64'h0, r);
      cmd(`FLK_OP_QPI_EX, 4, 0);
      see(64'h3, {qpi_mode, wrap_length_field});
      pulse(0);
      see(64'h0, {qpi_mode, dummy_count_field, wrap_length_field});
      rdl(1);
      see(64'h1, r);
      tick(8);
      results();
   end
endmodule
